//--- rtl/scs_pkg.sv
// Constants for the system clock source select block.
// Assumes a single 40 MHz clock and an AXI4-Lite register bus.
package scs_pkg;
    // Register byte offsets
    localparam logic [7:0] OSC_CONTROL_REG_OFS     = 8'h00;
    localparam logic [7:0] OSC_CONTROL_REG_TWO_OFS = 8'h04;
    localparam logic [7:0] CONFIG_WORD_HIGH_OFS    = 8'h08;
    localparam logic [7:0] OSC_TUNE_REG_OFS        = 8'h0C;
    localparam logic [7:0] STATUS_OFS              = 8'h10;

    // osc_control_reg fields
    localparam int SEL_LSB   = 0;
    localparam int FSTAT_BIT = 3;
    localparam int IFS_LSB   = 4;
    // osc_control_reg_two fields
    localparam int RUN_BIT   = 2;
    // osc_tune_reg fields
    localparam int LFPICK_BIT = 7;
    // config_word_high fields
    localparam int MODE_LSB      = 0;
    localparam int SWCTL_BIT     = 5;
    localparam int DIVOUT_BIT    = 6;
    localparam int MCLEAR_EN_BIT = 7;

    // Reset values
    localparam logic [1:0] SEL_RST    = 2'h0;
    localparam logic [2:0] IFS_RST    = 3'h3;
    localparam logic       RUN_RST    = 1'b1;
    localparam logic [3:0] MODE_RST   = 4'h2;
    localparam logic [7:0] CFG_RST    = 8'h82;

    // Internal frequency select codes
    localparam logic [2:0] IFS_SLOW   = 3'h0;

    // Primary oscillator mode codes
    localparam logic [3:0] MODE_LOWPWR  = 4'h0;
    localparam logic [3:0] MODE_MIDXTAL = 4'h1;
    localparam logic [3:0] MODE_HIXTAL  = 4'h2;
    localparam logic [3:0] MODE_RCOSC   = 4'h3;
    localparam logic [3:0] MODE_EXTCLK  = 4'h4;

    // Amplifier gain codes
    localparam logic [1:0] GAIN_OFF  = 2'h0;
    localparam logic [1:0] GAIN_LOW  = 2'h1;
    localparam logic [1:0] GAIN_MID  = 2'h2;
    localparam logic [1:0] GAIN_HIGH = 2'h3;

    // Clock source codes, one-hot
    localparam logic [3:0] SRC_PRI  = 4'h1;
    localparam logic [3:0] SRC_SEC  = 4'h2;
    localparam logic [3:0] SRC_SLOW = 4'h4;
    localparam logic [3:0] SRC_FAST = 4'h8;

    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
    localparam logic [1:0] DIV4_LAST  = 2'h3;
endpackage : scs_pkg

//--- rtl/scs_sync.sv
// Two-flop synchroniser for one level.
// Assumes the input is asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module scs_sync
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic d_i,
    output var  logic q_o
);
    logic meta;
    logic next_meta;
    logic next_q;

    always_comb
    begin
        next_meta = d_i;
        next_q    = meta;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta <= 1'b0;
            q_o  <= 1'b0;
        end
        else
        begin
            meta <= next_meta;
            q_o  <= next_q;
        end
    end
endmodule : scs_sync
`default_nettype wire

//--- rtl/scs_glitchfree.sv
// Glitch-free switch stage: a source is enabled only after the
// gates of the other sources are closed and it reports ready, each step on the system clock.
// Assumes oscillator-ready levels arrive already synchronised.
`timescale 1ns/1ps
`default_nettype none
module scs_glitchfree
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [3:0] want_i,
    input  wire logic [3:0] ready_i,
    output var  logic [3:0] gate_o
);
    logic [3:0] next_gate;

    // R14: break before make
    always_comb
    begin
        next_gate = gate_o;
        if (gate_o != want_i)
        begin
            if ((gate_o & ~want_i) != 4'h0)
                next_gate = gate_o & want_i;
            else if ((want_i & ready_i) != 4'h0)
                next_gate = want_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            gate_o <= scs_pkg::SRC_PRI;
        else
            gate_o <= next_gate;
    end
endmodule : scs_glitchfree
`default_nettype wire

//--- rtl/scs_clock_select.sv
// System clock source selection with AXI4-Lite registers.
// Assumes oscillator ready and pin inputs are asynchronous.
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1: Two-bit select picks internal, secondary, primary
// R2: Primary source stays until software changes select
// R3: Slow internal only at code 000, pick clear
// R4: Run bit works only with control enable
// R5: Run bit set runs, clear stops primary
// R6: Never stop primary while it clocks system
// R7: Five primary modes from four-bit config
// R8: Crystal modes set low, mid, high gain
// R9: Clock output pin toggles at quarter rate
// R10: Input pin is master clear unless disabled
// R11: Oscillator pins used only by needing modes
// R12: Frequency code decodes 16 MHz down to 31 kHz
// R13: Status bit shows primary or internal clock
// R14: Switch sources only at synchronised safe points
// R15: Block primary shutdown while primary selected
module scs_clock_select
(
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        pri_ready_i,
    input  wire logic        sec_ready_i,
    input  wire logic        slow_ready_i,
    input  wire logic        fast_ready_i,
    input  wire logic        input_only_pin_i,
    output var  logic        pri_osc_enable_o,
    output var  logic [1:0]  amp_gain_o,
    output var  logic [3:0]  clk_gate_o,
    output var  logic [2:0]  fast_divider_o,
    output var  logic        osc_pin_in_used_o,
    output var  logic        osc_pin_out_used_o,
    output var  logic        osc_pin_out_o,
    output var  logic        osc_pin_out_oe_o,
    output var  logic        master_clear_n_o,
    output var  logic        input_only_pin_o
);
    typedef enum logic [3:0] {
        SCS_SRC_PRI  = 4'h1,
        SCS_SRC_SEC  = 4'h2,
        SCS_SRC_SLOW = 4'h4,
        SCS_SRC_FAST = 4'h8
    } scs_src_e;

    // Source wanted by select and internal settings
    function automatic scs_src_e src_decode(input logic [1:0] sel,
        input logic [2:0] ifs, input logic pick);
        scs_src_e r;
        r = SCS_SRC_PRI;
        case (1'b1)
            sel[1]:
                // R3: slow only on code 000, pick clear
                if (ifs == scs_pkg::IFS_SLOW && !pick)
                    r = SCS_SRC_SLOW;
                else
                    r = SCS_SRC_FAST;
            sel[0]: r = SCS_SRC_SEC;
            default: r = SCS_SRC_PRI;
        endcase
        return r;
    endfunction : src_decode

    logic [1:0]  system_clock_select;
    logic [2:0]  internal_freq_select;
    logic        primary_run_bit;
    logic        low_freq_source_pick;
    logic [7:0]  config_word_high;
    logic [1:0]  next_sel;
    logic [2:0]  next_ifs;
    logic        next_run, next_pick;
    logic [7:0]  next_cfg;
    logic        aw_held, w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        next_aw_held, next_w_held;
    logic [7:0]  next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0]  next_w_strb;
    logic        next_bvalid, next_rvalid, do_write;
    logic [1:0]  next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic [3:0]  mode;
    logic [3:0]  want, gate, ready_s;
    logic        pin_s;
    logic [1:0]  div_cnt, next_div_cnt;
    logic        next_pri_en, next_in_used, next_out_used, next_out;
    logic        next_oe, next_clear_n, next_pin, mode_rcosc;
    logic [1:0]  next_gain;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_rdy
            scs_sync u_sync
            (
                .clk_i   (mclk_i),
                .rst_n_i (rst_n_i),
                .d_i     ((gi == 0) ? pri_ready_i :
                          (gi == 1) ? sec_ready_i :
                          (gi == 2) ? slow_ready_i : fast_ready_i),
                .q_o     (ready_s[gi])
            );
        end
    endgenerate

    scs_sync u_pin_sync
    (
        .clk_i   (mclk_i),
        .rst_n_i (rst_n_i),
        .d_i     (input_only_pin_i),
        .q_o     (pin_s)
    );

    assign mode    = config_word_high[scs_pkg::MODE_LSB +: 4];
    assign mode_rcosc = (mode == scs_pkg::MODE_RCOSC);
    // R1: select decode
    assign want    = src_decode(system_clock_select, internal_freq_select,
                                low_freq_source_pick);

    scs_glitchfree u_switch
    (
        .clk_i   (mclk_i),
        .rst_n_i (rst_n_i),
        .want_i  (want),
        .ready_i (ready_s),
        .gate_o  (gate)
    );

    // Bus write channel and register updates
    always_comb
    begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        do_write    = aw_held && w_held && !s_axi_bvalid;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp  = s_axi_bresp;
        next_sel    = system_clock_select;
        next_ifs    = internal_freq_select;
        next_run    = primary_run_bit;
        next_pick   = low_freq_source_pick;
        next_cfg    = config_word_high;
        if (do_write)
        begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = scs_pkg::AXI_OKAY;
            case (aw_addr)
                scs_pkg::OSC_CONTROL_REG_OFS:
                    if (w_strb[0])
                    begin
                        // R2: select changes only by software
                        next_sel = w_data[scs_pkg::SEL_LSB +: 2];
                        next_ifs = w_data[scs_pkg::IFS_LSB +: 3];
                    end
                scs_pkg::OSC_CONTROL_REG_TWO_OFS:
                    if (w_strb[0])
                        next_run = w_data[scs_pkg::RUN_BIT];
                scs_pkg::CONFIG_WORD_HIGH_OFS:
                    if (w_strb[0])
                        next_cfg = w_data[7:0];
                scs_pkg::OSC_TUNE_REG_OFS:
                    if (w_strb[0])
                        next_pick = w_data[scs_pkg::LFPICK_BIT];
                scs_pkg::STATUS_OFS: next_bresp = scs_pkg::AXI_OKAY;
                default: next_bresp = scs_pkg::AXI_SLVERR;
            endcase
        end
    end

    // Bus read channel
    always_comb
    begin
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rdata  = s_axi_rdata;
        next_rresp  = s_axi_rresp;
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rdata  = 32'h0;
            next_rresp  = scs_pkg::AXI_OKAY;
            case (s_axi_araddr)
                scs_pkg::OSC_CONTROL_REG_OFS:
                begin
                    next_rdata[scs_pkg::SEL_LSB +: 2] = system_clock_select;
                    next_rdata[scs_pkg::IFS_LSB +: 3] = internal_freq_select;
                    // R13: primary vs internal status
                    next_rdata[scs_pkg::FSTAT_BIT] = gate[0];
                end
                scs_pkg::OSC_CONTROL_REG_TWO_OFS:
                    next_rdata[scs_pkg::RUN_BIT] = primary_run_bit;
                scs_pkg::CONFIG_WORD_HIGH_OFS:
                    next_rdata[7:0] = config_word_high;
                scs_pkg::OSC_TUNE_REG_OFS:
                    next_rdata[scs_pkg::LFPICK_BIT] = low_freq_source_pick;
                scs_pkg::STATUS_OFS:
                    next_rdata[7:0] = {ready_s, gate};
                default: next_rresp = scs_pkg::AXI_SLVERR;
            endcase
        end
    end

    // Oscillator, gain and pin control
    always_comb
    begin
        // R4: run bit only with control enable
        // R5: run bit set runs, clear stops
        // R6: R15: never stop while selected
        next_pri_en = !config_word_high[scs_pkg::SWCTL_BIT] ||
                      primary_run_bit || want[0] || gate[0];
        // R7: R8: mode to amplifier gain
        case (mode)
            scs_pkg::MODE_LOWPWR:  next_gain = scs_pkg::GAIN_LOW;
            scs_pkg::MODE_MIDXTAL: next_gain = scs_pkg::GAIN_MID;
            scs_pkg::MODE_HIXTAL:  next_gain = scs_pkg::GAIN_HIGH;
            default:               next_gain = scs_pkg::GAIN_OFF;
        endcase
        if (!next_pri_en)
            next_gain = scs_pkg::GAIN_OFF;
        // R11: pins claimed only by needing modes
        next_in_used  = (mode <= scs_pkg::MODE_EXTCLK);
        next_out_used = (mode <= scs_pkg::MODE_HIXTAL) ||
                        ((mode_rcosc || mode == scs_pkg::MODE_EXTCLK) &&
                         config_word_high[scs_pkg::DIVOUT_BIT]);
        // R9: quarter-rate clock output
        next_div_cnt = div_cnt + 2'h1;
        next_oe  = next_out_used && (mode > scs_pkg::MODE_HIXTAL);
        next_out = next_oe && div_cnt[1];
        // R10: master clear unless disabled
        next_clear_n = config_word_high[scs_pkg::MCLEAR_EN_BIT] ? pin_s : 1'b1;
        next_pin     = config_word_high[scs_pkg::MCLEAR_EN_BIT] ? 1'b0 : pin_s;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            system_clock_select  <= scs_pkg::SEL_RST;
            internal_freq_select <= scs_pkg::IFS_RST;
            primary_run_bit      <= scs_pkg::RUN_RST;
            low_freq_source_pick <= 1'b0;
            config_word_high     <= scs_pkg::CFG_RST;
            aw_held              <= 1'b0;
            w_held               <= 1'b0;
            aw_addr              <= 8'h0;
            w_data               <= 32'h0;
            w_strb               <= 4'h0;
            s_axi_bvalid         <= 1'b0;
            s_axi_bresp          <= 2'h0;
            s_axi_rvalid         <= 1'b0;
            s_axi_rdata          <= 32'h0;
            s_axi_rresp          <= 2'h0;
            s_axi_awready        <= 1'b0;
            s_axi_wready         <= 1'b0;
            s_axi_arready        <= 1'b0;
            div_cnt              <= 2'h0;
            pri_osc_enable_o     <= 1'b1;
            amp_gain_o           <= scs_pkg::GAIN_HIGH;
            clk_gate_o           <= scs_pkg::SRC_PRI;
            fast_divider_o       <= scs_pkg::IFS_RST;
            osc_pin_in_used_o    <= 1'b1;
            osc_pin_out_used_o   <= 1'b1;
            osc_pin_out_o        <= 1'b0;
            osc_pin_out_oe_o     <= 1'b0;
            master_clear_n_o     <= 1'b1;
            input_only_pin_o     <= 1'b0;
        end
        else
        begin
            system_clock_select  <= next_sel;
            internal_freq_select <= next_ifs;
            primary_run_bit      <= next_run;
            low_freq_source_pick <= next_pick;
            config_word_high     <= next_cfg;
            aw_held              <= next_aw_held;
            w_held               <= next_w_held;
            aw_addr              <= next_aw_addr;
            w_data               <= next_w_data;
            w_strb               <= next_w_strb;
            s_axi_bvalid         <= next_bvalid;
            s_axi_bresp          <= next_bresp;
            s_axi_rvalid         <= next_rvalid;
            s_axi_rdata          <= next_rdata;
            s_axi_rresp          <= next_rresp;
            s_axi_awready        <= !next_aw_held && !next_bvalid;
            s_axi_wready         <= !next_w_held && !next_bvalid;
            s_axi_arready        <= !next_rvalid && !s_axi_arready;
            div_cnt              <= next_div_cnt;
            pri_osc_enable_o     <= next_pri_en;
            amp_gain_o           <= next_gain;
            clk_gate_o           <= gate;
            // R12: frequency code to postscaler
            fast_divider_o       <= internal_freq_select;
            osc_pin_in_used_o    <= next_in_used;
            osc_pin_out_used_o   <= next_out_used;
            osc_pin_out_o        <= next_out;
            osc_pin_out_oe_o     <= next_oe;
            master_clear_n_o     <= next_clear_n;
            input_only_pin_o     <= next_pin;
        end
    end
endmodule : scs_clock_select
`default_nettype wire

//--- tb/scs_clock_select_sva.sv
// Port checker for the clock source select block.
// Assumes it is bound onto scs_clock_select.
`timescale 1ns/1ps
`default_nettype none
module scs_clock_select_sva
(
    input wire logic       mclk_i,
    input wire logic       rst_n_i,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_arready,
    input wire logic       sec_ready_i,
    input wire logic       pri_osc_enable_o,
    input wire logic [1:0] amp_gain_o,
    input wire logic [3:0] clk_gate_o,
    input wire logic       osc_pin_in_used_o,
    input wire logic       osc_pin_out_oe_o,
    input wire logic       master_clear_n_o,
    input wire logic       input_only_pin_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    AST_GATE_ONEHOT: assert property ($onehot0(clk_gate_o))
        else $error("more than one clock gate open");
    AST_GATE_BREAK: assert property
        ($changed(clk_gate_o) && clk_gate_o != 4'h0 |-> $past(clk_gate_o) == 4'h0)
        else $error("gate moved without a closed cycle");
    AST_GATE_BOUND: assert property
        (clk_gate_o == 4'h0 |-> ##[1:12] clk_gate_o != 4'h0)
        else $error("no source gated after switch");
    AST_GATE_READY: assert property
        ($rose(clk_gate_o[1]) |-> $past(sec_ready_i, 2))
        else $error("secondary gated before it was ready");
    AST_PRI_HOLD: assert property (clk_gate_o[0] |-> pri_osc_enable_o)
        else $error("primary stopped while gated");
    AST_GAIN_OFF: assert property
        ((!pri_osc_enable_o) [*2] |-> amp_gain_o == scs_pkg::GAIN_OFF)
        else $error("amplifier gain on with primary stopped");
    AST_CLEAR_EXCL: assert property
        (!master_clear_n_o |-> !input_only_pin_o)
        else $error("pin used as data and master clear");
    AST_OE_PIN: assert property (osc_pin_out_oe_o |-> osc_pin_in_used_o)
        else $error("clock output driven without oscillator input");
    AST_B_ONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted during read response");
endmodule : scs_clock_select_sva
bind scs_clock_select scs_clock_select_sva u_sva (.mclk_i, .rst_n_i,
    .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_arready, .sec_ready_i,
    .pri_osc_enable_o, .amp_gain_o, .clk_gate_o, .osc_pin_in_used_o,
    .osc_pin_out_oe_o, .master_clear_n_o, .input_only_pin_o);
`default_nettype wire

//--- tb/scs_clock_select_tb_top.sv
// Testbench for the clock source select block.
// Assumes the design is reached over AXI4-Lite at 40 MHz.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        check_count++; \
        if ((g) !== (e)) \
        begin \
            failures++; \
            $display("[ERR] %s exp %0h got %0h", nm, e, g); \
        end \
    end
module scs_clock_select_tb_top;
    logic        mclk_i = 1'b0, rst_n_i = 1'b0, pri_ready_i = 1'b0;
    logic        sec_ready_i = 1'b1, slow_ready_i = 1'b1, fast_ready_i = 1'b1;
    logic        input_only_pin_i = 1'b1, s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, pri_osc_enable_o, osc_pin_in_used_o;
    logic        osc_pin_out_used_o, osc_pin_out_o, osc_pin_out_oe_o;
    logic        master_clear_n_o, input_only_pin_o;
    logic [1:0]  s_axi_bresp, s_axi_rresp, amp_gain_o;
    logic [31:0] s_axi_rdata;
    logic [3:0]  clk_gate_o;
    logic [2:0]  fast_divider_o;
    int          failures = 0, check_count = 0, cyc = 0;
    scs_clock_select uut (.mclk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pri_ready_i, .sec_ready_i,
        .slow_ready_i, .fast_ready_i, .input_only_pin_i, .pri_osc_enable_o,
        .amp_gain_o, .clk_gate_o, .fast_divider_o, .osc_pin_in_used_o,
        .osc_pin_out_used_o, .osc_pin_out_o, .osc_pin_out_oe_o,
        .master_clear_n_o, .input_only_pin_o);
    initial
    begin
        forever #12.5 mclk_i = ~mclk_i;
    end
    // Primary oscillator comes ready a cycle after it is enabled
    always @(posedge mclk_i)
        pri_ready_i <= pri_osc_enable_o;
    task automatic end_of_test;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            end_of_test();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge mclk_i);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        `CHK("bresp", er, s_axi_bresp)
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [31:0] m, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge mclk_i);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        `CHK("rresp", er, s_axi_rresp)
        `CHK("rdata", ed, s_axi_rdata & m)
    endtask : rd
    task automatic wait_gate(input logic [3:0] e);
        int n;
        n = 0;
        while (clk_gate_o !== e && n < 40)
        begin
            @(posedge mclk_i);
            n++;
        end
        `CHK("clk_gate_o", e, clk_gate_o)
    endtask : wait_gate
    initial
    begin
        logic [2:0] fq[4];
        logic       pk[4];
        logic [3:0] eg[4];
        logic [1:0] g;
        int         hi, ri, pv;
        fq = '{3'h0, 3'h0, 3'h7, 3'h1};
        pk = '{1'b0, 1'b1, 1'b0, 1'b0};
        eg = '{scs_pkg::SRC_SLOW, scs_pkg::SRC_FAST, scs_pkg::SRC_FAST,
               scs_pkg::SRC_FAST};
        tick(12);
        rst_n_i <= 1'b1;
        tick(10);
        rd(8'h00, 32'h38, 32'hFF, scs_pkg::AXI_OKAY);
        rd(8'h04, 32'h04, 32'hFF, scs_pkg::AXI_OKAY);
        rd(8'h08, 32'h82, 32'hFF, scs_pkg::AXI_OKAY);
        rd(8'h10, 32'hF1, 32'hFF, scs_pkg::AXI_OKAY);
        `CHK("clk_gate_o", scs_pkg::SRC_PRI, clk_gate_o)
        `CHK("fast_divider_o", 3'h3, fast_divider_o)
        wr(8'h14, 32'h1, scs_pkg::AXI_SLVERR);
        rd(8'h14, 32'h0, 32'h0, scs_pkg::AXI_SLVERR);
        wr(8'h08, 32'hA2, scs_pkg::AXI_OKAY);
        wr(8'h04, 32'h00, scs_pkg::AXI_OKAY);
        sec_ready_i <= 1'b0;
        tick(8);
        `CHK("pri_osc_enable_o", 1'b1, pri_osc_enable_o)
        wr(8'h00, 32'h31, scs_pkg::AXI_OKAY);
        tick(3);
        `CHK("clk_gate_o", 4'h0, clk_gate_o)
        sec_ready_i <= 1'b1;
        wait_gate(scs_pkg::SRC_SEC);
        tick(4);
        `CHK("pri_osc_enable_o", 1'b0, pri_osc_enable_o)
        rd(8'h00, 32'h31, 32'hFF, scs_pkg::AXI_OKAY);
        wr(8'h04, 32'h04, scs_pkg::AXI_OKAY);
        tick(4);
        `CHK("pri_osc_enable_o", 1'b1, pri_osc_enable_o)
        wr(8'h08, 32'h82, scs_pkg::AXI_OKAY);
        wr(8'h04, 32'h00, scs_pkg::AXI_OKAY);
        tick(4);
        `CHK("pri_osc_enable_o", 1'b1, pri_osc_enable_o)
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h0C, {24'h0, pk[i], 7'h0}, scs_pkg::AXI_OKAY);
            g = (i % 2) ? 2'h3 : 2'h2;
            wr(8'h00, {25'h0, fq[i], 2'h0, g}, scs_pkg::AXI_OKAY);
            wait_gate(eg[i]);
            tick(1);
            `CHK("fast_divider_o", fq[i], fast_divider_o)
        end
        wr(8'h00, 32'h30, scs_pkg::AXI_OKAY);
        wait_gate(scs_pkg::SRC_PRI);
        for (int m = 0; m < 8; m++)
        begin
            wr(8'h08, 32'h80 | m, scs_pkg::AXI_OKAY);
            tick(4);
            g = (m < 3) ? 2'(m + 1) : scs_pkg::GAIN_OFF;
            `CHK("amp_gain_o", g, amp_gain_o)
            `CHK("osc_pin_in_used_o", m < 5, osc_pin_in_used_o)
            `CHK("osc_pin_out_used_o", m < 3, osc_pin_out_used_o)
            `CHK("osc_pin_out_oe_o", 1'b0, osc_pin_out_oe_o)
        end
        wr(8'h08, 32'hC3, scs_pkg::AXI_OKAY);
        tick(4);
        `CHK("osc_pin_out_oe_o", 1'b1, osc_pin_out_oe_o)
        hi = 0;
        ri = 0;
        pv = osc_pin_out_o;
        repeat (16)
        begin
            @(posedge mclk_i);
            hi += (osc_pin_out_o === 1'b1);
            ri += (osc_pin_out_o === 1'b1 && pv == 0);
            pv = osc_pin_out_o;
        end
        `CHK("divided_clock_output high cycles", 8, hi)
        `CHK("divided_clock_output rises", 4, ri)
        wr(8'h08, 32'h82, scs_pkg::AXI_OKAY);
        input_only_pin_i <= 1'b0;
        tick(6);
        `CHK("master_clear_n_o", 1'b0, master_clear_n_o)
        `CHK("input_only_pin_o", 1'b0, input_only_pin_o)
        wr(8'h08, 32'h02, scs_pkg::AXI_OKAY);
        tick(6);
        `CHK("master_clear_n_o", 1'b1, master_clear_n_o)
        input_only_pin_i <= 1'b1;
        tick(6);
        `CHK("input_only_pin_o", 1'b1, input_only_pin_o)
        wr(8'h00, 32'h72, scs_pkg::AXI_OKAY);
        wait_gate(scs_pkg::SRC_FAST);
        rst_n_i <= 1'b0;
        tick(3);
        rst_n_i <= 1'b1;
        tick(4);
        `CHK("clk_gate_o", scs_pkg::SRC_PRI, clk_gate_o)
        `CHK("fast_divider_o", 3'h3, fast_divider_o)
        end_of_test();
    end
endmodule : scs_clock_select_tb_top
`default_nettype wire
